// ---- mpucrs_top.sv ----
// Protection unit control, region selection and access check.
// How it works
// - Disabled: default map for all, no checks.
// - No background: miss on all regions faults.
// - Background acts as region -1 for privileged.
// - Background on: unprivileged miss still faults.
// - Background bit ignored while unit disabled.
// - Handler bit clear: escalated handlers bypass checks.
// - Handler bit set: escalated handlers are checked.
// - Control space always execute-never, strongly-ordered.
// - Control space and vector table always permitted.
// - Eight-bit region select; only values 0 to 7 have regions.
// - Base write, valid clear: use current select.
// - Base write, valid set: update select first.
// - Base read: valid zero, select in low bits.
// - Base field bits 31 to N, rest reserved.
// - 4 GB region covers whole map, base zero.
// - Base aligned to size; compare upper bits.
// - Region size is two to size plus one; size codes below 4 give 32 bytes.
// - Overlap: highest numbered matching region wins.
//
// The address map and register access over Avalon-MM were left to the implementer.
`timescale 1ns/1ps
module mpucrs_top
  import mpucrs_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // Avalon-MM register slave
  input wire logic [7:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  // Settings from the attribute and size register, one entry per region
  input wire logic [NUM_REGIONS-1:0] region_enable,
  input wire logic [4:0] region_size [NUM_REGIONS],
  // Selected region index towards the attribute and size register
  output logic [7:0] region_select,
  // Processor access to check and its result one cycle later
  input wire mpucrs_access_t access,
  output mpucrs_result_t result
);

  ////////////////////////////////////////////////////////////////////////
  // Register state

  mpucrs_bus_state_t bus_state_q, bus_state_d;
  logic waitrequest_q, waitrequest_d;
  logic [31:0] readdata_q, readdata_d;
  mpucrs_ctrl_t ctrl_q, ctrl_d;
  logic [7:0] select_q, select_d;
  logic [26:0] base_q [NUM_REGIONS];
  logic [26:0] base_d [NUM_REGIONS];
  logic fault_seen_q, fault_seen_d;
  logic [31:0] fault_addr_q, fault_addr_d;
  mpucrs_result_t result_q, result_d;

  logic commit_write;
  logic [31:0] ctrl_word;
  logic [31:0] select_word;
  logic [31:0] base_word;
  logic [31:0] fstat_word;
  logic [31:0] rd_value;
  logic [31:0] base_merged;
  logic [7:0] base_target;
  logic [NUM_REGIONS-1:0] hit;
  logic [31:0] ctrl_merged;
  logic [31:0] select_merged;
  logic [31:0] base_mask;
  logic select_exists;
  logic target_exists;
  logic clear_fault;

  ////////////////////////////////////////////////////////////////////////
  // Decode helpers

  // Region numbers above seven are kept but have no storage behind them.
  function automatic logic region_exists(input logic [7:0] r);
    return r < 8'(NUM_REGIONS);
  endfunction

  // The control space sits at a fixed place in the map.
  function automatic logic in_control_space(input logic [31:0] a);
    return a[31:12] == SCS_PREFIX;
  endfunction

  // The vector table window starts at address zero.
  function automatic logic in_vector_table(input logic [31:0] a);
    return a < VECTOR_TABLE_LIMIT;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Read view of the registers

  assign ctrl_word = {29'h00000000, ctrl_q};
  assign select_word = {24'h000000, select_q};
  assign fstat_word = {31'h00000000, fault_seen_q};

  // reserved below N
  // The address field is masked with the selected region's size, so the
  // reserved bits between N-1 and 5 always read as zero.
  assign select_exists = region_exists(select_q);
  assign base_mask = region_mask(region_size[select_q[2:0]]);

  always_comb begin
    base_word = {28'h0000000, select_q[3:0]};
    if (select_exists) begin
      base_word[31:BASE_ADDR_LSB] = base_q[select_q[2:0]] &
        base_mask[31:BASE_ADDR_LSB];
    end
  end

  // Unmapped offsets read as zero and ignore writes.
  always_comb begin
    unique case (address)
      OFS_CTRL: rd_value = ctrl_word;
      OFS_SELECT: rd_value = select_word;
      OFS_BASE: rd_value = base_word;
      OFS_FSTAT: rd_value = fstat_word;
      OFS_FADDR: rd_value = fault_addr_q;
      default: rd_value = 32'h00000000;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // Bus handshake

  // Each request is answered with one wait cycle. The write lands at the
  // edge where the master sees waitrequest low, so a held request is
  // never applied twice.
  always_comb begin
    bus_state_d = bus_state_q;
    waitrequest_d = 1'b1;
    readdata_d = readdata_q;
    unique case (bus_state_q)
      MPUCRS_BUS_IDLE: begin
        if (read || write) begin
          bus_state_d = MPUCRS_BUS_ANSWER;
          waitrequest_d = 1'b0;
          readdata_d = read ? rd_value : 32'h00000000;
        end
      end
      MPUCRS_BUS_ANSWER: begin
        bus_state_d = MPUCRS_BUS_IDLE;
      end
    endcase
  end

  assign commit_write = write && (bus_state_q == MPUCRS_BUS_ANSWER);

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      bus_state_q <= MPUCRS_BUS_IDLE;
      waitrequest_q <= 1'b1;
      readdata_q <= 32'h00000000;
    end else begin
      bus_state_q <= bus_state_d;
      waitrequest_q <= waitrequest_d;
      readdata_q <= readdata_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Control, region select and base address registers

  assign base_merged = lane_merge(base_word, writedata, byteenable);
  assign ctrl_merged = lane_merge(ctrl_word, writedata, byteenable);
  assign select_merged = lane_merge(select_word, writedata, byteenable);

  assign base_target = base_merged[BASE_VALID_BIT] ?
    {4'h0, base_merged[3:0]} : select_q;
  assign target_exists = region_exists(base_target);

  always_comb begin
    ctrl_d = ctrl_q;
    select_d = select_q;
    base_d = base_q;
    if (commit_write) begin
      unique case (address)
        OFS_CTRL: begin
          ctrl_d = mpucrs_ctrl_t'(ctrl_merged[2:0]);
        end
        OFS_SELECT: begin
          select_d = select_merged[7:0];
        end
        OFS_BASE: begin
          select_d = base_target;
          if (target_exists) begin
            base_d[base_target[2:0]] = base_merged[31:BASE_ADDR_LSB];
          end
        end
        default: begin
          ctrl_d = ctrl_q;
        end
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      ctrl_q <= mpucrs_ctrl_t'(CTRL_RST);
      select_q <= SELECT_RST;
      for (int i = 0; i < NUM_REGIONS; i++) begin
        base_q[i] <= BASE_RST;
      end
    end else begin
      ctrl_q <= ctrl_d;
      select_q <= select_d;
      base_q <= base_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Region comparators

  for (genvar g = 0; g < NUM_REGIONS; g++) begin : g_match
    mpucrs_region_match u_match (
      .addr(access.addr),
      .base(base_q[g]),
      .size(region_size[g]),
      .enable(region_enable[g]),
      .hit(hit[g])
    );
  end

  ////////////////////////////////////////////////////////////////////////
  // Access check

  // The result is registered, so a fault is seen one cycle after the
  // access; this keeps the long compare chain off the output pins.
  always_comb begin
    logic active;
    logic scs;
    logic vtab;
    logic any_hit;
    logic [2:0] top;
    active = 1'b0;
    scs = 1'b0;
    vtab = 1'b0;
    any_hit = 1'b0;
    top = 3'h0;
    result_d = '0;
    result_d.valid = access.valid;
    for (int i = 0; i < NUM_REGIONS; i++) begin
      if (hit[i]) begin
        any_hit = 1'b1;
        top = 3'(i);
      end
    end
    scs = in_control_space(access.addr);
    vtab = in_vector_table(access.addr);
    active = ctrl_q.enable &&
      !(access.escalated && !ctrl_q.handler_protection_enable);
    result_d.execute_never = scs;
    result_d.strongly_ordered = scs;
    if (!active) begin
      result_d.default_map = 1'b1;
    end else if (scs || vtab) begin
      result_d.default_map = 1'b1;
    end else if (any_hit) begin
      result_d.region_hit = 1'b1;
      result_d.region = top;
    end else if (ctrl_q.privileged_background_enable &&
                 access.privileged) begin
      result_d.background = 1'b1;
      result_d.default_map = 1'b1;
    end else begin
      result_d.memory_management_fault = access.valid;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Fault record

  // A new fault in the same cycle as the software clear keeps the flag
  // set, so no fault can slip by unseen. The address is only captured
  // while the flag is clear, which keeps the first fault of a burst.

  // Only a one written to bit 0 clears the flag; a zero leaves it alone.
  assign clear_fault = commit_write && (address == OFS_FSTAT) &&
    byteenable[0] && writedata[FSTAT_SEEN_BIT];

  always_comb begin
    fault_seen_d = fault_seen_q;
    fault_addr_d = fault_addr_q;
    if (clear_fault) begin
      fault_seen_d = 1'b0;
    end
    if (result_q.memory_management_fault) begin
      fault_seen_d = 1'b1;
    end
    // A fault still in the result stage is older and owns the address, so
    // a back-to-back pair keeps the first address.
    if (result_d.memory_management_fault && !fault_seen_q &&
        !result_q.memory_management_fault) begin
      fault_addr_d = access.addr;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      fault_seen_q <= 1'b0;
      fault_addr_q <= FADDR_RST;
      result_q <= '0;
    end else begin
      fault_seen_q <= fault_seen_d;
      fault_addr_q <= fault_addr_d;
      result_q <= result_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs

  assign readdata = readdata_q;
  assign waitrequest = waitrequest_q;
  assign region_select = select_q;
  assign result = result_q;

endmodule

// ---- mpucrs_pkg.sv ----
// Shared constants, carrier types and helpers of the protection unit.
package mpucrs_pkg;

  localparam int unsigned NUM_REGIONS = 8;

  // Register byte offsets on the bus.
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_SELECT = 8'h04;
  localparam logic [7:0] OFS_BASE = 8'h08;
  localparam logic [7:0] OFS_FSTAT = 8'h0C;
  localparam logic [7:0] OFS_FADDR = 8'h10;

  // Field positions.
  localparam int unsigned CTRL_ENABLE_BIT = 0;
  localparam int unsigned CTRL_HANDLER_BIT = 1;
  localparam int unsigned CTRL_PRIVBG_BIT = 2;
  localparam int unsigned BASE_VALID_BIT = 4;
  localparam int unsigned BASE_ADDR_LSB = 5;
  localparam int unsigned FSTAT_SEEN_BIT = 0;

  // Reset values.
  localparam logic [2:0] CTRL_RST = 3'h0;
  localparam logic [7:0] SELECT_RST = 8'h00;
  localparam logic [26:0] BASE_RST = 27'h0000000;
  localparam logic [31:0] FADDR_RST = 32'h00000000;

  // Size codes and fixed address spaces.
  localparam logic [4:0] SIZE_MIN = 5'h04;
  localparam logic [19:0] SCS_PREFIX = 20'hE000E;
  localparam logic [31:0] VECTOR_TABLE_LIMIT = 32'h00000400;

  typedef enum logic {
    MPUCRS_BUS_IDLE = 1'b0,
    MPUCRS_BUS_ANSWER = 1'b1
  } mpucrs_bus_state_t;

  typedef struct packed {
    logic privileged_background_enable;
    logic handler_protection_enable;
    logic enable;
  } mpucrs_ctrl_t;

  typedef struct packed {
    logic valid;
    logic [31:0] addr;
    logic privileged;
    logic fetch;
    logic escalated;
  } mpucrs_access_t;

  typedef struct packed {
    logic valid;
    logic memory_management_fault;
    logic region_hit;
    logic background;
    logic default_map;
    logic [2:0] region;
    logic execute_never;
    logic strongly_ordered;
  } mpucrs_result_t;

  // Mask of the address bits compared for a size code (bits 31 down to N).
  function automatic logic [31:0] region_mask(input logic [4:0] size);
    logic [5:0] n;
    logic [31:0] m;
    n = (size < SIZE_MIN) ? {1'b0, SIZE_MIN} + 6'h01 : {1'b0, size} + 6'h01;
    m = 32'h00000000;
    for (int b = 0; b < 32; b++) begin
      m[b] = (6'(b) >= n);
    end
    return m;
  endfunction

  // Byte-lane merge of a bus write into an old word.
  function automatic logic [31:0] lane_merge(input logic [31:0] old_w,
                                             input logic [31:0] new_w,
                                             input logic [3:0] be);
    logic [31:0] r;
    r = old_w;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[8*i +: 8] = new_w[8*i +: 8];
      end
    end
    return r;
  endfunction

endpackage

// ---- mpucrs_region_match.sv ----
// Address comparator for one protection region.
`timescale 1ns/1ps
module mpucrs_region_match
  import mpucrs_pkg::*;
(
  // Access address under test
  input wire logic [31:0] addr,
  // Region settings
  input wire logic [26:0] base,
  input wire logic [4:0] size,
  input wire logic enable,
  // Result
  output logic hit
);

  logic [31:0] mask;

  // aligned base compare
  // Only the bits above the size boundary are compared.
  // whole map region
  // A 4 GB code leaves an empty mask, so every address hits.
  assign mask = region_mask(size);
  assign hit = enable &&
    (((addr ^ {base, 5'h00}) & mask) == 32'h00000000);

endmodule

// ---- mpucrs_checker.sv ----
// Port checker for the protection unit, bound to its top module.
`timescale 1ns/1ps
module mpucrs_checker
  import mpucrs_pkg::*;
(
  // Clock, reset and register bus
  input wire logic mclk,
  input wire logic rstn,
  input wire logic [7:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  input wire logic [31:0] readdata,
  input wire logic waitrequest,
  // Regions and check path
  input wire logic [NUM_REGIONS-1:0] region_enable,
  input wire logic [4:0] region_size [NUM_REGIONS],
  input wire logic [7:0] region_select,
  input wire mpucrs_access_t access,
  input wire mpucrs_result_t result
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rstn);
  logic [2:0] ctl_q;
  logic done;
  logic spc;
  logic act;
  assign done = !waitrequest && (read || write);
  assign spc = access.addr[31:12] == SCS_PREFIX
    || access.addr < VECTOR_TABLE_LIMIT;
  assign act = access.valid && ctl_q[0] && !(access.escalated && !ctl_q[1]);
  ////////////////////////////////////////////////////////////////////////////
  // The control write lands at the completing edge, as in the unit.
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      ctl_q <= CTRL_RST;
    end else if (write && done && address == OFS_CTRL && byteenable[0]) begin
      ctl_q <= writedata[2:0];
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  property p_off;
    access.valid && !ctl_q[0] |=>
      result.default_map && !result.memory_management_fault;
  endproperty
  a_off: assert property (p_off)
    else $error("check applied while disabled");
  property p_bg_ignored;
    access.valid && !ctl_q[0] && ctl_q[2] |=> !result.background;
  endproperty
  a_bg_ignored: assert property (p_bg_ignored)
    else $error("background used while disabled");
  property p_miss;
    act && !spc && region_enable == 8'h00
      && !(ctl_q[2] && access.privileged) |=> result.memory_management_fault;
  endproperty
  a_miss: assert property (p_miss)
    else $error("miss without fault");
  property p_bg_priv;
    act && ctl_q[2] && access.privileged |=> !result.memory_management_fault;
  endproperty
  a_bg_priv: assert property (p_bg_priv)
    else $error("privileged fault with background");
  property p_bypass;
    access.valid && !ctl_q[1] && access.escalated |=>
      result.default_map && !result.memory_management_fault;
  endproperty
  a_bypass: assert property (p_bypass)
    else $error("escalated handler checked");
  property p_scs_attr;
    access.valid && access.addr[31:12] == SCS_PREFIX |=>
      result.execute_never && result.strongly_ordered;
  endproperty
  a_scs_attr: assert property (p_scs_attr)
    else $error("control space attributes wrong");
  property p_spc_ok;
    access.valid && spc |=> !result.memory_management_fault;
  endproperty
  a_spc_ok: assert property (p_spc_ok)
    else $error("control space or vectors faulted");
  property p_keep_sel;
    write && done && address == OFS_BASE
      && !(byteenable[0] && writedata[BASE_VALID_BIT]) |=> $stable(region_select);
  endproperty
  a_keep_sel: assert property (p_keep_sel)
    else $error("select changed by base write");
  property p_upd_sel;
    write && done && address == OFS_BASE && byteenable[0]
      && writedata[BASE_VALID_BIT] |=>
      region_select == {4'h0, $past(writedata[3:0])};
  endproperty
  a_upd_sel: assert property (p_upd_sel)
    else $error("select not updated by base write");
  property p_base_rd;
    read && done && address == OFS_BASE |->
      readdata[4:0] == {1'b0, region_select[3:0]};
  endproperty
  a_base_rd: assert property (p_base_rd)
    else $error("base read low bits wrong");
  c_fault: cover property (result.memory_management_fault);
  c_hit: cover property (result.region_hit && result.region == 3'h5);
  c_bg: cover property (result.background);
endmodule
bind mpucrs_top mpucrs_checker u_chk (.mclk(mclk), .rstn(rstn),
  .address(address), .read(read), .write(write), .writedata(writedata),
  .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest),
  .region_enable(region_enable), .region_size(region_size),
  .region_select(region_select), .access(access), .result(result));

// ---- mpucrs_core_model.sv ----
// Processor core model that issues accesses for checking.
`timescale 1ns/1ps
module mpucrs_core_model
  import mpucrs_pkg::*;
(
  // Clock
  input wire logic mclk,
  // Access towards the unit
  output mpucrs_access_t access
);
  initial begin
    access = '0;
  end
  // The idle address is inverted so a stale value never looks valid.
  task automatic issue(input logic [31:0] a, input logic pr, input logic es);
    @(posedge mclk);
    access <= {1'b1, a, pr, 1'b0, es};
    @(posedge mclk);
    access <= {1'b0, ~a, 3'h0};
  endtask
endmodule

// ---- testbench.sv ----
// Self-checking bench for the protection unit.
`timescale 1ns/1ps
module testbench
  import mpucrs_pkg::*;
;
  logic mclk, rstn, read, write, waitrequest;
  logic [7:0] address, region_enable, region_select;
  logic [31:0] writedata, readdata, rd;
  logic [3:0] byteenable;
  logic [4:0] region_size [NUM_REGIONS];
  mpucrs_access_t access;
  mpucrs_result_t result;
  int miscompares = 0;
  int tests_run = 0;
  mpucrs_top dut (.mclk(mclk), .rstn(rstn), .address(address), .read(read),
    .write(write), .writedata(writedata), .byteenable(byteenable),
    .readdata(readdata), .waitrequest(waitrequest),
    .region_enable(region_enable), .region_size(region_size),
    .region_select(region_select), .access(access), .result(result));
  mpucrs_core_model core (.mclk(mclk), .access(access));
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  task summarize;
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    tests_run++;
    if (got !== exp) begin
      $display("FAIL %0t %s got %h exp %h", $time, m, got, exp);
      miscompares++;
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Bus cycle held until waitrequest is seen low at a rising edge.
  task xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge mclk);
    address <= a;
    writedata <= d;
    write <= wr;
    read <= !wr;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (waitrequest !== 1'b0 && n < 20);
    rd = readdata;
    read <= 1'b0;
    write <= 1'b0;
    if (waitrequest !== 1'b0) begin
      $display("FAIL %0t bus timeout", $time);
      miscompares++;
      summarize();
    end
  endtask
  task rdc(input logic [7:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h00000000);
    chk(rd, e, "register read");
  endtask
  // Flags are fault, hit, background, default map; region only on a hit.
  task acc(input logic [31:0] a, input logic pr, input logic es,
           input logic [3:0] f, input logic [2:0] r);
    core.issue(a, pr, es);
    #1;
    chk({24'h0, result.valid, result.memory_management_fault,
         result.region_hit, result.background, result.default_map,
         result.region_hit ? result.region : 3'h0}, {24'h0, 1'b1, f, r},
        "access");
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task t_reset;
    rdc(OFS_SELECT, 32'h00000000);
    rdc(8'h40, 32'h00000000);
    acc(32'h20002000, 1'b0, 1'b0, 4'h1, 3'h0);
    xfer(1'b1, OFS_CTRL, 32'hFFFFFFF4);
    rdc(OFS_CTRL, 32'h00000004);
    acc(32'h20002000, 1'b1, 1'b0, 4'h1, 3'h0);
    $display("test reset done");
  endtask
  task t_select;
    xfer(1'b1, OFS_SELECT, 32'hFFFFFF07);
    rdc(OFS_SELECT, 32'h00000007);
    xfer(1'b1, OFS_BASE, 32'h200007E3);
    rdc(OFS_BASE, 32'h20000407);
    xfer(1'b1, OFS_BASE, 32'h200007F2);
    rdc(OFS_BASE, 32'h20000402);
    chk({24'h0, region_select}, 32'h00000002, "select");
    $display("test select done");
  endtask
  task t_regions;
    xfer(1'b1, OFS_BASE, 32'h20000015);
    region_enable <= 8'h24;
    xfer(1'b1, OFS_CTRL, 32'h00000001);
    acc(32'h20000500, 1'b0, 1'b0, 4'h4, 3'h5);
    acc(32'h20002000, 1'b1, 1'b0, 4'h8, 3'h0);
    rdc(OFS_FSTAT, 32'h00000001);
    rdc(OFS_FADDR, 32'h20002000);
    xfer(1'b1, OFS_FSTAT, 32'h00000001);
    rdc(OFS_FSTAT, 32'h00000000);
    acc(32'hE000E010, 1'b0, 1'b0, 4'h1, 3'h0);
    chk({30'h0, result.execute_never, result.strongly_ordered}, 32'h3, "scs");
    acc(32'h00000100, 1'b0, 1'b0, 4'h1, 3'h0);
    $display("test regions done");
  endtask
  task t_background;
    xfer(1'b1, OFS_CTRL, 32'h00000005);
    acc(32'h30000000, 1'b1, 1'b0, 4'h3, 3'h0);
    acc(32'h20000500, 1'b1, 1'b0, 4'h4, 3'h5);
    acc(32'h30000000, 1'b0, 1'b0, 4'h8, 3'h0);
    acc(32'h30000000, 1'b0, 1'b1, 4'h1, 3'h0);
    xfer(1'b1, OFS_CTRL, 32'h00000007);
    acc(32'h30000000, 1'b0, 1'b1, 4'h8, 3'h0);
    region_enable <= 8'h00;
    acc(32'h30000000, 1'b0, 1'b0, 4'h8, 3'h0);
    $display("test background done");
  endtask
  task t_size;
    xfer(1'b1, OFS_BASE, 32'h12345610);
    rdc(OFS_BASE, 32'h00000000);
    region_enable <= 8'h01;
    acc(32'hF0000000, 1'b0, 1'b0, 4'h4, 3'h0);
    region_enable <= 8'h04;
    acc(32'h200007FC, 1'b0, 1'b0, 4'h4, 3'h2);
    acc(32'h20000800, 1'b0, 1'b0, 4'h8, 3'h0);
    $display("test size done");
  endtask
  initial begin
    rstn = 1'b0;
    read = 1'b0;
    write = 1'b0;
    address = 8'h00;
    writedata = 32'h00000000;
    byteenable = 4'hF;
    region_enable = 8'h00;
    foreach (region_size[i]) begin
      region_size[i] = 5'h09;
    end
    region_size[0] = 5'h1F;
    region_size[5] = 5'h0B;
    repeat (3) @(posedge mclk);
    rstn <= 1'b1;
    t_reset;
    t_select;
    t_regions;
    t_background;
    t_size;
    summarize;
  end
endmodule
